// file: hdl/ehb_arbiter.sv
// External bus hold arbiter: lets another master take the external bus.
// Assumes the bus controller reports cycle and strobe activity on mclk,
// and that pad logic resolves the enables and pull devices given here.
`timescale 1ns/1ps
`default_nettype none
module ehb_arbiter #(
  parameter int AW = ehb_pkg::ADDR_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic arbitration_enable,
  input wire logic slave_mode_select,
  input wire logic shared_pin_direction,
  input wire logic hold_req_n_in,
  input wire logic bus_grant_n_in,
  input wire logic ext_cycle_active,
  input wire logic ext_strobe_active,
  input wire logic ext_access_need,
  input wire logic cs_open_drain,
  input wire logic [AW-1:0] core_addr,
  output logic bus_grant_out_n,
  output logic bus_grant_oe,
  output logic bus_request_out_n,
  output logic bus_request_oe,
  output logic arb_pins_owned,
  output logic hold_active,
  output logic ext_cycle_block,
  output logic core_stall,
  output logic addr_data_oe,
  output logic ale_pulldown_en,
  output logic cmd_pullup_en,
  output logic cs_drive_oe,
  output logic shared_pin_port_ctrl,
  output logic shared_pin_oe,
  output logic [ehb_pkg::XPER_NUM-1:0] xper_sel,
  output logic xper_word,
  output logic xper_demux
);

  // ==========================================================================
  // Pin synchronisation.
  logic [1:0] pins_sync;
  logic req_low;
  logic grant_in_low;
  logic take_req;
  logic is_slave;

  // Bit 0 is the takeover request, bit 1 the grant pin used as an input.
  ehb_sync #(
    .WIDTH(2)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .pin_in({bus_grant_n_in, hold_req_n_in}),
    .level_q(pins_sync)
  );

  // In slave mode the grant pin carries the partner's request, so it also
  // counts as a takeover request; that is what removes the glue logic.
  assign req_low = (pins_sync[0] == ehb_pkg::PIN_ACTIVE);
  assign grant_in_low = (pins_sync[1] == ehb_pkg::PIN_ACTIVE);
  assign take_req = req_low || (is_slave && grant_in_low);

  // ==========================================================================
  // Mode and pin ownership.
  logic armed_q;

  assign is_slave = (slave_mode_select == ehb_pkg::SLAVE_MODE);

  // Ownership is sticky: once enabled, the pins never return to the port.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= ehb_pkg::ARMED_RST;
    end else if (ce && arbitration_enable) begin
      armed_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Arbitration state machine.
  ehb_pkg::ehb_state_t state_q;
  ehb_pkg::ehb_state_t state_d;
  logic bus_quiet;

  // A strobe can trail the cycle flag, so both must be idle before release.
  assign bus_quiet = !ext_cycle_active && !ext_strobe_active;

  // Entry needs the enable bit; exit needs only the request going high.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ehb_pkg::EHB_ST_OWN: begin
        if (arbitration_enable && take_req) begin
          state_d = ehb_pkg::EHB_ST_DRAIN;
        end
      end
      ehb_pkg::EHB_ST_DRAIN: begin
        if (!take_req) begin
          state_d = ehb_pkg::EHB_ST_OWN;
        end else if (bus_quiet) begin
          state_d = ehb_pkg::EHB_ST_HOLD;
        end
      end
      ehb_pkg::EHB_ST_HOLD: begin
        if (!take_req) begin
          state_d = ehb_pkg::EHB_ST_OWN;
        end
      end
      default: begin
        state_d = ehb_pkg::EHB_ST_OWN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ehb_pkg::EHB_ST_OWN;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Registered pin outputs, computed from the next state so they move
  // together with the state register.
  logic grant_n_q;
  logic request_n_q;
  logic hold_q;
  logic hold_d;

  assign hold_d = (state_d == ehb_pkg::EHB_ST_HOLD);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      grant_n_q <= ehb_pkg::PIN_INACTIVE;
      hold_q <= 1'b0;
    end else if (ce) begin
      hold_q <= hold_d;
      grant_n_q <= hold_d ? ehb_pkg::PIN_ACTIVE : ehb_pkg::PIN_INACTIVE;
    end
  end

  // The request never starts the regain itself; it only informs the
  // outside arbiter, which may then withdraw its own grant.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      request_n_q <= ehb_pkg::PIN_INACTIVE;
    end else if (ce) begin
      request_n_q <= (hold_d && ext_access_need) ?
        ehb_pkg::PIN_ACTIVE : ehb_pkg::PIN_INACTIVE;
    end
  end

  // Pins are driven only once owned; slave mode turns the grant around.
  assign bus_grant_out_n = grant_n_q;
  assign bus_grant_oe = armed_q && !is_slave;
  assign bus_request_out_n = request_n_q;
  assign bus_request_oe = armed_q;
  assign arb_pins_owned = armed_q;

  // ==========================================================================
  // Bus interface treatment and core stall.
  assign hold_active = hold_q;
  // No new external cycle may start while draining or in hold.
  assign ext_cycle_block = (state_q != ehb_pkg::EHB_ST_OWN);
  assign core_stall = hold_q && ext_access_need;
  assign addr_data_oe = !hold_q;
  assign ale_pulldown_en = hold_q;
  assign cmd_pullup_en = hold_q;
  // Push/pull selects keep driving high in hold; open drain ones float.
  assign cs_drive_oe = !(hold_q && cs_open_drain);
  // The shared pin floats unless software set its direction bit.
  assign shared_pin_port_ctrl = hold_q;
  assign shared_pin_oe = hold_q && shared_pin_direction;

  // ==========================================================================
  // On-chip peripheral window decode.
  logic [AW-1:0] xper_base [ehb_pkg::XPER_NUM];

  assign xper_base[0] = ehb_pkg::XPER0_BASE;
  assign xper_base[1] = ehb_pkg::XPER1_BASE;
  assign xper_base[2] = ehb_pkg::XPER2_BASE;

  ehb_xbus_dec #(
    .NUM(ehb_pkg::XPER_NUM),
    .AW(AW)
  ) u_xdec (
    .addr(core_addr),
    .base(xper_base),
    .mask(ehb_pkg::XPER_MASK),
    .word_wide(ehb_pkg::XPER_WORD_WIDE),
    .demux(ehb_pkg::XPER_DEMUX),
    .sel(xper_sel),
    .hit(),
    .sel_word(xper_word),
    .sel_demux(xper_demux)
  );

  // ==========================================================================
  // Assertions.
  property p_no_entry_disabled;
    @(posedge mclk) disable iff (!rst_n || !ce)
      (state_q == ehb_pkg::EHB_ST_OWN) && !arbitration_enable |=>
        state_q == ehb_pkg::EHB_ST_OWN;
  endproperty
  a_no_entry_disabled: assert property (p_no_entry_disabled)
    else $error("hold entered while arbitration disabled");

  property p_grant_after_quiet;
    @(posedge mclk) disable iff (!rst_n || !ce)
      $fell(grant_n_q) |-> $past(bus_quiet) && $past(take_req);
  endproperty
  a_grant_after_quiet: assert property (p_grant_after_quiet)
    else $error("grant given during an active cycle");

  property p_hold_kept;
    @(posedge mclk) disable iff (!rst_n || !ce)
      (state_q == ehb_pkg::EHB_ST_HOLD) && take_req |=>
        (state_q == ehb_pkg::EHB_ST_HOLD) && !grant_n_q;
  endproperty
  a_hold_kept: assert property (p_hold_kept)
    else $error("hold left while request still low");

  property p_release;
    @(posedge mclk) disable iff (!rst_n || !ce)
      (state_q == ehb_pkg::EHB_ST_HOLD) && !take_req |=>
        grant_n_q && !hold_active && addr_data_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("bus not regained after request went high");

  property p_request_in_hold;
    @(posedge mclk) disable iff (!rst_n)
      !bus_request_out_n |-> hold_q && (state_q == ehb_pkg::EHB_ST_HOLD);
  endproperty
  a_request_in_hold: assert property (p_request_in_hold)
    else $error("bus request outside hold");

  property p_armed_sticky;
    @(posedge mclk) disable iff (!rst_n)
      armed_q |=> armed_q && bus_request_oe;
  endproperty
  a_armed_sticky: assert property (p_armed_sticky)
    else $error("arbitration pins lost their function");

  property p_slave_grant_input;
    @(posedge mclk) disable iff (!rst_n)
      is_slave |-> !bus_grant_oe;
  endproperty
  a_slave_grant_input: assert property (p_slave_grant_input)
    else $error("grant driven in slave mode");

  property p_hold_pins;
    @(posedge mclk) disable iff (!rst_n)
      hold_q |-> !addr_data_oe && ale_pulldown_en && cmd_pullup_en &&
        (cs_drive_oe == !cs_open_drain);
  endproperty
  a_hold_pins: assert property (p_hold_pins)
    else $error("bus pins not released in hold");

  property p_stall;
    @(posedge mclk) disable iff (!rst_n)
      core_stall == (hold_q && ext_access_need);
  endproperty
  a_stall: assert property (p_stall)
    else $error("core stalled without external need");

  property p_drain_blocks;
    @(posedge mclk) disable iff (!rst_n || !ce)
      (state_q == ehb_pkg::EHB_ST_DRAIN) && !bus_quiet && take_req |=>
        grant_n_q;
  endproperty
  a_drain_blocks: assert property (p_drain_blocks)
    else $error("grant given before strobes ended");

  c_enter_hold: cover property (@(posedge mclk) disable iff (!rst_n)
    $fell(grant_n_q));
  c_request_in_hold: cover property (@(posedge mclk) disable iff (!rst_n)
    !bus_request_out_n ##[1:20] bus_grant_out_n);
  c_disable_in_hold: cover property (@(posedge mclk) disable iff (!rst_n)
    hold_q && !arbitration_enable);
  c_slave_hold: cover property (@(posedge mclk) disable iff (!rst_n)
    hold_q && is_slave);

endmodule
`default_nettype wire

// file: hdl/ehb_sync.sv
// Three-stage synchroniser for asynchronous active-low pins.
// Assumes the pins may change at any time relative to mclk.
`timescale 1ns/1ps
`default_nettype none
module ehb_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_q
);

  // ==========================================================================
  // Per bit: a change is accepted once stages two and three agree.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q <= ehb_pkg::PIN_INACTIVE;
        s2_q <= ehb_pkg::PIN_INACTIVE;
        s3_q <= ehb_pkg::PIN_INACTIVE;
        level_q[i] <= ehb_pkg::PIN_INACTIVE;
      end else if (ce) begin
        s1_q <= pin_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          level_q[i] <= s3_q;
        end
      end
    end

    // The accepted level only moves to a value both late stages held.
    property p_sync_agree;
      @(posedge mclk) disable iff (!rst_n)
        ce && (level_q[i] != $past(level_q[i])) |->
          $past(s2_q) == $past(s3_q);
    endproperty
    a_sync_agree: assert property (p_sync_agree)
      else $error("synchroniser output moved without agreement");
  end

endmodule
`default_nettype wire

// file: hdl/ehb_xbus_dec.sv
// Address window decoder for the on-chip peripheral bus.
// Assumes windows are fixed and non-overlapping; every matching window is selected.
`timescale 1ns/1ps
`default_nettype none
module ehb_xbus_dec #(
  parameter int NUM = ehb_pkg::XPER_NUM,
  parameter int AW = ehb_pkg::ADDR_W
) (
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] base [NUM],
  input wire logic [AW-1:0] mask,
  input wire logic [NUM-1:0] word_wide,
  input wire logic [NUM-1:0] demux,
  output logic [NUM-1:0] sel,
  output logic hit,
  output logic sel_word,
  output logic sel_demux
);

  // ==========================================================================
  // One comparator per peripheral window.
  for (genvar i = 0; i < NUM; i++) begin : g_win
    assign sel[i] = ((addr & mask) == (base[i] & mask));
  end

  // Width and address-bus options follow the matching window.
  assign hit = |sel;
  assign sel_word = |(sel & word_wide);
  assign sel_demux = |(sel & demux);

endmodule
`default_nettype wire

// file: include/ehb_pkg.sv
// Shared constants for the external bus hold arbiter.
// Assumes a single 200 MHz system clock and active-low arbitration pins.
package ehb_pkg;

  // ==========================================================================
  // Arbitration state machine.
  typedef enum logic [1:0] {
    EHB_ST_OWN   = 2'b00,
    EHB_ST_DRAIN = 2'b01,
    EHB_ST_HOLD  = 2'b10
  } ehb_state_t;

  // ==========================================================================
  // Pin levels and reset values.
  localparam logic PIN_INACTIVE = 1'b1;
  localparam logic PIN_ACTIVE = 1'b0;
  localparam logic ARMED_RST = 1'b0;
  localparam logic SLAVE_MODE = 1'b1;
  localparam int SYNC_STAGES = 3;

  // ==========================================================================
  // On-chip peripheral bus windows (fixed at build time).
  localparam int XPER_NUM = 3;
  localparam int ADDR_W = 24;
  localparam logic [ADDR_W-1:0] XPER0_BASE = 24'h00ef00;
  localparam logic [ADDR_W-1:0] XPER1_BASE = 24'h00ee00;
  localparam logic [ADDR_W-1:0] XPER2_BASE = 24'h00ed00;
  localparam logic [ADDR_W-1:0] XPER_MASK = 24'hffff00;
  localparam logic [XPER_NUM-1:0] XPER_WORD_WIDE = 3'h7;
  localparam logic [XPER_NUM-1:0] XPER_DEMUX = 3'h7;

endpackage

// file: testbench/ehb_other_master.sv
// Behavioural model of the other bus master together with its glue logic.
// Assumes it shares mclk with the arbiter; its request pin is still
// synchronised by the arbiter, so it may change on any edge.
`timescale 1ns/1ps
`default_nettype none
module ehb_other_master (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic want,
  input wire logic yield_en,
  input wire logic [3:0] lag,
  input wire logic bus_request_out_n,
  output logic hold_req_n
);
  logic [3:0] wait_q;
  logic gave_q;

  // =========================================================================
  // Request generation.
  // Once it has yielded, the model stays off the bus until its own demand
  // drops, so it never snatches the bus straight back from the device.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_req_n <= 1'b1;
      wait_q <= 4'h0;
      gave_q <= 1'b0;
    end else if (!want) begin
      hold_req_n <= 1'b1; // Free release without a device request.
      wait_q <= 4'h0;
      gave_q <= 1'b0;
    end else if (gave_q) begin
      hold_req_n <= 1'b1;
    end else if (yield_en && !bus_request_out_n) begin
      // Glue withdraws the other grant after a prompt or slow lag.
      if (wait_q >= lag) begin
        hold_req_n <= 1'b1;
        gave_q <= 1'b1;
      end
      wait_q <= wait_q + 4'h1;
    end else begin
      hold_req_n <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_external_bus_hold_arbiter.sv
// Self-checking bench for the external bus hold arbiter.
// Assumes ehb_pkg is compiled first and the other master model is present.
`timescale 1ns/1ps
`default_nettype none
module tb_external_bus_hold_arbiter;
  logic mclk, rst_n, en, slv, sdir, gnt_in, cyc, stb, need, od;
  logic want, yield_en, hreq_n, g_prev, ce;
  logic [3:0] lag;
  logic [23:0] addr;
  logic g_n, g_oe, r_n, r_oe, owned, hold, blk, stall, ad_oe, ale_pd;
  logic cmd_pu, cs_oe, sp_ctrl, sp_oe, xw, xd;
  logic [2:0] xsel;
  logic q[$];
  int n_mismatch, samples_checked, busy, i;

  // =========================================================================
  // Clock, device and far-side model.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ehb_other_master u_ehb_other_master (.mclk(mclk), .rst_n(rst_n),
    .want(want), .yield_en(yield_en), .lag(lag),
    .bus_request_out_n(r_n), .hold_req_n(hreq_n));

  ehb_arbiter u_ehb_arbiter (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .arbitration_enable(en), .slave_mode_select(slv),
    .shared_pin_direction(sdir), .hold_req_n_in(hreq_n),
    .bus_grant_n_in(gnt_in), .ext_cycle_active(cyc),
    .ext_strobe_active(stb), .ext_access_need(need), .cs_open_drain(od),
    .core_addr(addr), .bus_grant_out_n(g_n), .bus_grant_oe(g_oe),
    .bus_request_out_n(r_n), .bus_request_oe(r_oe), .arb_pins_owned(owned),
    .hold_active(hold), .ext_cycle_block(blk), .core_stall(stall),
    .addr_data_oe(ad_oe), .ale_pulldown_en(ale_pd), .cmd_pullup_en(cmd_pu),
    .cs_drive_oe(cs_oe), .shared_pin_port_ctrl(sp_ctrl),
    .shared_pin_oe(sp_oe), .xper_sel(xsel), .xper_word(xw),
    .xper_demux(xd));

  // =========================================================================
  // Checking helpers.
  task automatic chk(input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("n_mismatch=%0d samples_checked=%0d", n_mismatch,
      samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Every visible grant edge must match the oldest noted expectation; an
  // edge with nothing noted is itself a fault.
  always @(negedge mclk) begin
    if (rst_n && g_oe === 1'b1 && g_prev !== g_n) begin
      if (q.size() == 0)
        chk(g_prev, g_n);
      else
        chk(q.pop_front(), g_n);
    end
    g_prev = g_n;
  end

  // Starts on a falling edge so the grant is never read as it is launched.
  task automatic wait_grant(input logic v);
    @(negedge mclk);
    for (int k = 0; k < 40 && g_n !== v; k++)
      @(negedge mclk);
    chk(v, g_n);
  endtask

  task automatic chk_hold(input logic h);
    chk(!h, ad_oe);
    chk(h, ale_pd);
    chk(h, cmd_pu);
    chk(!(h && od), cs_oe);
    chk(h, sp_ctrl);
    chk(h && sdir, sp_oe);
    chk(h, hold);
    chk(h, blk);
  endtask

  // Other master asks while a random-length external cycle is running.
  task automatic take_bus;
    busy = $urandom_range(12, 0);
    q.push_back(1'b0);
    @(posedge mclk);
    want <= 1'b1;
    cyc <= 1'b1;
    stb <= 1'b1;
    od <= 1'($urandom);
    sdir <= 1'($urandom);
    for (i = 0; i < (busy > 4 ? busy : 4); i++) begin
      @(negedge mclk);
      chk(1'b1, g_n);
      @(posedge mclk);
      if (i + 1 >= busy) begin
        cyc <= 1'b0;
        stb <= 1'b0;
      end
    end
    wait_grant(1'b0);
    @(negedge mclk);
    chk_hold(1'b1);
    chk(1'b1, blk);
    chk(1'b0, stall);
    chk(1'b1, r_n);
  endtask

  // =========================================================================
  // Main sequence.
  initial begin
    {rst_n, en, slv, sdir, cyc, stb, need, od, want, yield_en} = '0;
    gnt_in = 1'b1;
    ce = 1'b1;
    lag = 4'h0;
    addr = 24'h000000;
    g_prev = 1'b1;
    void'($urandom(32'h3fe4));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    // Enable clear: the request must go unanswered.
    want <= 1'b1;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk(1'b1, g_n);
    chk(1'b0, owned);
    chk_hold(1'b0);
    // Let the withdrawn request settle through the synchroniser first, or
    // the stale low level would be taken as a fresh request.
    @(posedge mclk);
    want <= 1'b0;
    repeat (8) @(posedge mclk);
    en <= 1'b1;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk(1'b1, owned);
    chk(1'b1, g_oe);
    // Hold, then the device wants the bus back; glue yields promptly/slowly.
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge mclk);
      yield_en <= 1'b1;
      lag <= pass ? 4'hb : 4'h0;
      take_bus();
      @(posedge mclk);
      need <= 1'b1;
      @(negedge mclk);
      chk(1'b1, stall);
      q.push_back(1'b1);
      repeat (2) @(negedge mclk);
      chk(1'b0, r_n);
      wait_grant(1'b1);
      @(negedge mclk);
      chk(1'b1, r_n);
      chk_hold(1'b0);
      @(posedge mclk);
      need <= 1'b0;
      want <= 1'b0;
      yield_en <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    // Enable cleared during hold: hold lasts until the request goes high.
    take_bus();
    @(posedge mclk);
    en <= 1'b0;
    repeat (15) @(negedge mclk);
    chk(1'b0, g_n);
    q.push_back(1'b1);
    // Clock enable low freezes the synchroniser, so the raised request
    // must not end the hold until the enable returns.
    @(posedge mclk);
    ce <= 1'b0;
    want <= 1'b0;
    repeat (10) @(negedge mclk);
    chk(1'b0, g_n);
    chk(1'b1, hold);
    @(posedge mclk);
    ce <= 1'b1;
    wait_grant(1'b1);
    repeat (3) @(posedge mclk);
    want <= 1'b1;
    repeat (20) @(negedge mclk);
    chk(1'b1, g_n);
    chk(1'b1, owned);
    chk(1'b1, r_oe);
    @(posedge mclk);
    want <= 1'b0;
    repeat (8) @(posedge mclk);
    en <= 1'b1;
    slv <= 1'b1;
    // Slave mode: grant pin becomes an input that asks for the bus.
    repeat (2) @(negedge mclk);
    chk(1'b0, g_oe);
    @(posedge mclk);
    gnt_in <= 1'b0;
    for (int k = 0; k < 40 && hold !== 1'b1; k++)
      @(negedge mclk);
    chk(1'b1, hold);
    @(posedge mclk);
    gnt_in <= 1'b1;
    for (int k = 0; k < 40 && hold !== 1'b0; k++)
      @(negedge mclk);
    chk(1'b0, hold);
    // Peripheral windows, each hit and one miss.
    for (int w = 0; w < 4; w++) begin
      @(posedge mclk);
      addr <= {16'h00ef - 16'(w), 8'($urandom)};
      @(negedge mclk);
      chk(w < 3 ? 24'(1 << w) : 24'h000000, 24'(xsel));
      chk(w < 3 ? 2'h3 : 2'h0, {xw, xd});
    end
    end_of_test();
  end

  // Hang guard, far above the few hundred cycles the tests take.
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
